// ==== design/selfprog_section_read_control.sv ====
// section arbitration and read blocking for processor self-programming of flash
// assumes the core issues store_program_instruction as one-cycle strobes and the
// flash array reports completion with a one-cycle done pulse on the same clock
//
// Added by the designer: the address map and strobed register access.
module selfprog_section_read_control
  import selfprog_pkg::*;
#(
  parameter int LOADER_MIN_WORDS = 512,
  parameter int PAGE_BITS = 7
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [REG_AW-1:0] reg_addr_i,
  input wire logic [REG_DW-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [REG_DW-1:0] reg_rdata_o,
  input wire spm_req_t store_program_instruction_i,
  input wire logic [FLASH_AW-1:0] fetch_addr_i,
  output logic fetch_ok_o,
  output logic cpu_halt_o,
  output flash_cmd_t flash_cmd_o,
  input wire logic flash_done_i,
  input wire logic [1:0] boot_area_size_fuses_i,
  input wire logic reset_vector_select_fuse_i,
  input wire logic [3:0] loader_lock_bits_i,
  output logic [FLASH_AW-1:0] reset_vector_o
);
  localparam logic [FLASH_AW:0] FLASH_WORDS = (FLASH_AW+1)'(1) << FLASH_AW;
  localparam logic [FLASH_AW:0] MAX_LOADER_WORDS = (FLASH_AW+1)'(LOADER_MIN_WORDS) << 3;
  // largest loader starts where the stalling area begins, so any fuse value fits
  localparam logic [FLASH_AW-1:0] STALL_START = FLASH_AW'(FLASH_WORDS - MAX_LOADER_WORDS);
  localparam logic [FLASH_AW-1:0] PAGE_OFS_MASK = FLASH_AW'((1 << PAGE_BITS) - 1);

  function automatic logic [FLASH_AW-1:0] loader_start(input logic [1:0] size_fuses);
    logic [FLASH_AW:0] words;
    words = (FLASH_AW+1)'(LOADER_MIN_WORDS) << (~size_fuses);
    loader_start = FLASH_AW'(FLASH_WORDS - words);
  endfunction

  function automatic logic in_stall_area(input logic [FLASH_AW-1:0] a);
    in_stall_area = (a >= STALL_START);
  endfunction

  // fuse synchroniser: first stage feeds only the second
  logic [1:0] size_meta_reg, size_meta_next, size_reg, size_next;
  logic rstsel_meta_reg, rstsel_meta_next, rstsel_reg, rstsel_next;
  logic [3:0] lock_meta_reg, lock_meta_next, lock_reg, lock_next;

  always_comb begin
    size_meta_next = boot_area_size_fuses_i;
    size_next = size_meta_reg;
    rstsel_meta_next = reset_vector_select_fuse_i;
    rstsel_next = rstsel_meta_reg;
    lock_meta_next = loader_lock_bits_i;
    lock_next = lock_meta_reg;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      size_meta_reg <= FUSE_SYNC_RST;
      size_reg <= FUSE_SYNC_RST;
      rstsel_meta_reg <= 1'b1;
      rstsel_reg <= 1'b1;
      lock_meta_reg <= LOCK_SYNC_RST;
      lock_reg <= LOCK_SYNC_RST;
    end else begin
      size_meta_reg <= size_meta_next;
      size_reg <= size_next;
      rstsel_meta_reg <= rstsel_meta_next;
      rstsel_reg <= rstsel_next;
      lock_meta_reg <= lock_meta_next;
      lock_reg <= lock_next;
    end
  end

  logic [FLASH_AW-1:0] loader_base;
  logic pc_in_loader, tgt_in_loader, tgt_locked, op_selected, start_ok;

  always_comb begin
    loader_base = loader_start(size_reg);
    pc_in_loader = store_program_instruction_i.pc >= loader_base;
    tgt_in_loader = store_program_instruction_i.target >= loader_base;
    // lock bit 0 of each set programmed (0) forbids writes to its own area only
    tgt_locked = tgt_in_loader ? ~lock_reg[2] : ~lock_reg[0];
    reset_vector_o = rstsel_reg ? APP_RESET_VECTOR : loader_base;
  end

  // control/status register and operation sequencer
  prog_state_t state_reg, state_next;
  logic erase_sel_reg, erase_sel_next, write_sel_reg, write_sel_next;
  logic busy_reg, busy_next;
  flash_cmd_t cmd_reg, cmd_next;
  logic [REG_DW-1:0] rdata_reg, rdata_next;
  logic ctrl_wr, busy_clear;

  always_comb begin
    ctrl_wr = reg_we_i && (reg_addr_i == SELFPROG_CTRL_STATUS_OFS);
    busy_clear = ctrl_wr && reg_wdata_i[BUSY_CLEAR_BIT];
    op_selected = erase_sel_reg ^ write_sel_reg;
    start_ok = store_program_instruction_i.strobe && pc_in_loader && op_selected
      && !tgt_locked && (state_reg == ST_IDLE);
  end

  always_comb begin
    state_next = state_reg;
    erase_sel_next = erase_sel_reg;
    write_sel_next = write_sel_reg;
    busy_next = busy_reg;
    cmd_next = cmd_reg;
    cmd_next.start = 1'b0;
    if (ctrl_wr && state_reg == ST_IDLE) begin
      erase_sel_next = reg_wdata_i[ERASE_SEL_BIT];
      write_sel_next = reg_wdata_i[WRITE_SEL_BIT];
    end
    // clear only takes effect with no operation running; a start wins over it
    if (busy_clear && state_reg == ST_IDLE) begin
      busy_next = 1'b0;
    end
    case (state_reg)
      ST_IDLE: begin
        if (start_ok) begin
          cmd_next.start = 1'b1;
          cmd_next.erase = erase_sel_reg;
          // page alignment only here; fetch addressing stays word-wide
          cmd_next.addr = store_program_instruction_i.target & ~PAGE_OFS_MASK;
          busy_next = 1'b1;
          erase_sel_next = 1'b0;
          write_sel_next = 1'b0;
          if (in_stall_area(store_program_instruction_i.target)) begin
            state_next = ST_STALL;
          end else begin
            state_next = ST_CONC;
          end
        end
      end
      ST_CONC, ST_STALL: begin
        if (flash_done_i) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    rdata_next = '0;
    if (reg_re_i && reg_addr_i == SELFPROG_CTRL_STATUS_OFS) begin
      rdata_next[ACTIVE_BIT] = (state_reg != ST_IDLE);
      rdata_next[ERASE_SEL_BIT] = erase_sel_reg;
      rdata_next[WRITE_SEL_BIT] = write_sel_reg;
      rdata_next[BUSY_FLAG_BIT] = busy_reg;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      erase_sel_reg <= SELFPROG_CTRL_STATUS_RST[ERASE_SEL_BIT];
      write_sel_reg <= SELFPROG_CTRL_STATUS_RST[WRITE_SEL_BIT];
      busy_reg <= SELFPROG_CTRL_STATUS_RST[BUSY_FLAG_BIT];
      cmd_reg <= '0;
      rdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      erase_sel_reg <= erase_sel_next;
      write_sel_reg <= write_sel_next;
      busy_reg <= busy_next;
      cmd_reg <= cmd_next;
      rdata_reg <= rdata_next;
    end
  end

  always_comb begin
    flash_cmd_o = cmd_reg;
    reg_rdata_o = rdata_reg;
    cpu_halt_o = (state_reg == ST_STALL);
    // a fetch into the concurrent-read area gets no valid code while the busy flag is set
    fetch_ok_o = !(busy_reg && !in_stall_area(fetch_addr_i));
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_start;
    flash_cmd_o.start;
  endsequence

  sequence s_stall_start;
    flash_cmd_o.start && in_stall_area(flash_cmd_o.addr);
  endsequence

  property p_start_from_loader;
    s_start |-> $past(store_program_instruction_i.strobe && pc_in_loader);
  endproperty
  a_start_from_loader: assert property (p_start_from_loader) else $error("start without loader fetch");

  property p_app_no_effect;
    store_program_instruction_i.strobe && !pc_in_loader |=> !flash_cmd_o.start;
  endproperty
  a_app_no_effect: assert property (p_app_no_effect) else $error("application store had effect");

  property p_stall_halts;
    s_stall_start |-> cpu_halt_o;
  endproperty
  a_stall_halts: assert property (p_stall_halts) else $error("stalling op without halt");

  property p_conc_runs;
    flash_cmd_o.start && !in_stall_area(flash_cmd_o.addr) |-> !cpu_halt_o;
  endproperty
  a_conc_runs: assert property (p_conc_runs) else $error("concurrent op halted core");

  property p_halt_release;
    cpu_halt_o && flash_done_i |=> !cpu_halt_o;
  endproperty
  a_halt_release: assert property (p_halt_release) else $error("halt not released");

  property p_busy_during_op;
    (state_reg != ST_IDLE) |-> busy_reg;
  endproperty
  a_busy_during_op: assert property (p_busy_during_op) else $error("busy flag low during op");

  property p_busy_read;
    busy_reg && reg_re_i && reg_addr_i == SELFPROG_CTRL_STATUS_OFS |=> reg_rdata_o[BUSY_FLAG_BIT];
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy flag read as zero");

  property p_busy_holds;
    busy_reg && !busy_clear |=> busy_reg;
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("busy dropped without clear");

  property p_fetch_blocked;
    (state_reg != ST_IDLE) && !in_stall_area(fetch_addr_i) |-> !fetch_ok_o;
  endproperty
  a_fetch_blocked: assert property (p_fetch_blocked) else $error("concurrent area fetch allowed");

  property p_addr_latched;
    s_start ##1 (state_reg != ST_IDLE) [*2] |-> $stable(flash_cmd_o.addr);
  endproperty
  a_addr_latched: assert property (p_addr_latched) else $error("target address moved");

  property p_loader_in_stall;
    in_stall_area(loader_base);
  endproperty
  a_loader_in_stall: assert property (p_loader_in_stall) else $error("loader outside stalling area");

  property p_reset_vector;
    !rstsel_reg |-> reset_vector_o == loader_base;
  endproperty
  a_reset_vector: assert property (p_reset_vector) else $error("wrong reset vector");

  property p_conc_fetch_ok;
    (state_reg == ST_CONC) && in_stall_area(fetch_addr_i) |-> fetch_ok_o;
  endproperty
  a_conc_fetch_ok: assert property (p_conc_fetch_ok) else $error("stalling area fetch blocked");

  property p_stall_held;
    cpu_halt_o && !flash_done_i |=> cpu_halt_o;
  endproperty
  a_stall_held: assert property (p_stall_held) else $error("halt dropped before done");

  property p_app_lock;
    store_program_instruction_i.strobe && !tgt_in_loader && !lock_reg[0] |=> !flash_cmd_o.start;
  endproperty
  a_app_lock: assert property (p_app_lock) else $error("locked application page started");

  property p_loader_lock;
    store_program_instruction_i.strobe && tgt_in_loader && !lock_reg[2] |=> !flash_cmd_o.start;
  endproperty
  a_loader_lock: assert property (p_loader_lock) else $error("locked loader page started");

  property p_page_aligned;
    s_start |-> (flash_cmd_o.addr & PAGE_OFS_MASK) == '0;
  endproperty
  a_page_aligned: assert property (p_page_aligned) else $error("target not page aligned");

  property p_no_restart;
    store_program_instruction_i.strobe && (state_reg != ST_IDLE) |=> !flash_cmd_o.start && $stable(flash_cmd_o.addr);
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("strobe during op disturbed command");

  property p_loader_target_ok;
    store_program_instruction_i.strobe && pc_in_loader && tgt_in_loader && lock_reg[2] && op_selected
      && (state_reg == ST_IDLE) |=> flash_cmd_o.start;
  endproperty
  a_loader_target_ok: assert property (p_loader_target_ok) else $error("loader page not started");

  property p_rdata_idle;
    !(reg_re_i && reg_addr_i == SELFPROG_CTRL_STATUS_OFS) |=> reg_rdata_o == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");

  property p_busy_clear;
    busy_clear && (state_reg == ST_IDLE) && !start_ok |=> !busy_reg;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy clear ignored when idle");

  property p_halt_target;
    cpu_halt_o |-> in_stall_area(flash_cmd_o.addr);
  endproperty
  a_halt_target: assert property (p_halt_target) else $error("halt for concurrent target");

  property p_sel_autoclear;
    s_start |-> !erase_sel_reg && !write_sel_reg;
  endproperty
  a_sel_autoclear: assert property (p_sel_autoclear) else $error("select kept after start");
endmodule

// ==== include/selfprog_pkg.sv ====
// constants, types and states for the self-programming section/read control
// assumes one clock domain; fuses and lock bits arrive as slow static levels
// What this block does
// - erase or write starts only when the store instruction runs from the loader area.
// - store instructions fetched from the application area do nothing.
// - from the loader area any flash page may be targeted, loader pages too.
// - loader area boundary comes from the boot-area-size fuses.
// - application area write protection uses only the first lock bit set.
// - loader area write protection uses only the second lock bit set.
// - fixed split into concurrent-read area and stalling area, fuse independent.
// - programming the concurrent-read area keeps the core running.
// - programming the stalling area halts the core for the whole operation.
// - stall or concurrent is chosen by the target page area only.
// - concurrent-read area fetches are blocked while programming runs.
// - busy flag reads one while concurrent-read area is blocked.
// - busy flag stays set after completion until software clears it.
// - loader area always lies inside the stalling area.
// - page layout affects only erase and write, never fetch.
// - target address is latched at operation start.
// - reset vector is zero, or loader start when the select fuse is programmed.
package selfprog_pkg;
  localparam int FLASH_AW = 16;
  localparam int REG_AW = 4;
  localparam int REG_DW = 8;

  // register map
  localparam logic [REG_AW-1:0] SELFPROG_CTRL_STATUS_OFS = 4'h0;
  localparam logic [REG_DW-1:0] SELFPROG_CTRL_STATUS_RST = 8'h00;

  // field positions of selfprog_control_status
  localparam int ACTIVE_BIT = 0;
  localparam int ERASE_SEL_BIT = 1;
  localparam int WRITE_SEL_BIT = 2;
  localparam int BUSY_CLEAR_BIT = 4;
  localparam int BUSY_FLAG_BIT = 6;

  localparam logic [FLASH_AW-1:0] APP_RESET_VECTOR = 16'h0000;
  localparam logic [1:0] FUSE_SYNC_RST = 2'h3;
  localparam logic [3:0] LOCK_SYNC_RST = 4'hF;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONC = 2'b01,
    ST_STALL = 2'b10
  } prog_state_t;

  typedef struct packed {
    logic strobe;
    logic [FLASH_AW-1:0] pc;
    logic [FLASH_AW-1:0] target;
  } spm_req_t;

  typedef struct packed {
    logic start;
    logic erase;
    logic [FLASH_AW-1:0] addr;
  } flash_cmd_t;
endpackage

// ==== test/flash_array_model.sv ====
// flash array stand-in: answers each start with one done pulse
// assumes start is a one-cycle pulse on the shared clock
module flash_array_model
  import selfprog_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire flash_cmd_t flash_cmd_i,
  input wire logic [7:0] delay_i,
  output logic flash_done_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  // op length comes from delay_i, so tests pick prompt or slow
  always @(posedge ref_clk_i) begin
    flash_done_o <= !rst_i && !flash_cmd_i.start && (cnt == 1);
    if (rst_i) begin
      cnt <= 0;
    end else if (flash_cmd_i.start) begin
      cnt <= delay_i;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// ==== test/testbench.sv ====
// self-checking bench for the self-programming section/read control
// assumes the flash model above and a 25 MHz clock
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, a); end end
module testbench import selfprog_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [1:0] fz;
    logic [3:0] lk;
    logic [7:0] ctl;
    logic [15:0] pc;
    logic [15:0] tg;
    logic st;
    logic hl;
  } row_t;
  logic ref_clk_i = 0, rst_i = 1, we = 0, re = 0, sel = 1, ok, halt, done;
  logic [3:0] addr = '0, locks = 4'hF;
  logic [7:0] wdata = '0, rdata, rd_v, delay = 8'h06;
  logic [1:0] fz = 2'h3;
  logic [15:0] fetch = 16'h1000, rv;
  spm_req_t store_program_instruction = '0;
  flash_cmd_t cmd;
  int n_mismatch = 0, checked = 0;
  row_t rows[10] = '{
    '{2'h3, 4'hF, 8'h04, 16'hFE00, 16'h1234, 1'b1, 1'b0},
    '{2'h3, 4'hF, 8'h04, 16'h0100, 16'h1234, 1'b0, 1'b0},
    '{2'h3, 4'hF, 8'h02, 16'hFE10, 16'hFE80, 1'b1, 1'b1},
    '{2'h0, 4'hF, 8'h02, 16'hF000, 16'h2000, 1'b1, 1'b0},
    '{2'h3, 4'hF, 8'h04, 16'hF000, 16'h2000, 1'b0, 1'b0},
    '{2'h3, 4'hE, 8'h04, 16'hFE00, 16'h1234, 1'b0, 1'b0},
    '{2'h3, 4'hB, 8'h04, 16'hFE00, 16'h1234, 1'b1, 1'b0},
    '{2'h3, 4'hB, 8'h04, 16'hFE00, 16'hFE80, 1'b0, 1'b0},
    '{2'h3, 4'hF, 8'h04, 16'hFE00, 16'hF100, 1'b1, 1'b1},
    '{2'h3, 4'hF, 8'h06, 16'hFE00, 16'h1234, 1'b0, 1'b0}
  };
  always #20 ref_clk_i = ~ref_clk_i;
  selfprog_section_read_control i_selfprog_section_read_control (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .store_program_instruction_i(store_program_instruction),
    .fetch_addr_i(fetch), .fetch_ok_o(ok), .cpu_halt_o(halt), .flash_cmd_o(cmd),
    .flash_done_i(done), .boot_area_size_fuses_i(fz), .reset_vector_select_fuse_i(sel),
    .loader_lock_bits_i(locks), .reset_vector_o(rv));
  flash_array_model i_flash_array_model (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .flash_cmd_i(cmd), .delay_i(delay), .flash_done_o(done));
  task complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i); we <= 1'b1; addr <= a; wdata <= d;
    @(posedge ref_clk_i); we <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge ref_clk_i); re <= 1'b1; addr <= a;
    @(posedge ref_clk_i); re <= 1'b0;
    #1 rd_v = rdata;
  endtask
  // target is scrambled right after the strobe to show it was latched
  task fire(input logic [15:0] pc, input logic [15:0] tg);
    @(posedge ref_clk_i); store_program_instruction <= '{1'b1, pc, tg};
    @(posedge ref_clk_i); store_program_instruction <= '{1'b0, 16'h0000, 16'h5555};
    #1;
  endtask
  task wait_done;
    for (int i = 0; i < 300; i++) begin
      @(posedge ref_clk_i);
      #1;
      if (done === 1'b1) break;
    end
    `CHK("done", 1'b1, done)
    @(posedge ref_clk_i);
    #1;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_mismatch++;
    complete_run;
  end
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1 `CHK("rst halt", 1'b0, halt)
    `CHK("rst vector", APP_RESET_VECTOR, rv)
    rd(SELFPROG_CTRL_STATUS_OFS);
    `CHK("rst status", SELFPROG_CTRL_STATUS_RST, rd_v)
    rd(4'h5);
    `CHK("unmapped", 8'h00, rd_v)
    @(posedge ref_clk_i); sel <= 1'b0;
    foreach (rows[k]) begin
      @(posedge ref_clk_i); fz <= rows[k].fz; locks <= rows[k].lk;
      repeat (3) @(posedge ref_clk_i);
      #1 `CHK("vector", 16'(65536 - (512 << (3 - rows[k].fz))), rv)
      wr(SELFPROG_CTRL_STATUS_OFS, rows[k].ctl);
      fire(rows[k].pc, rows[k].tg);
      `CHK("start", rows[k].st, cmd.start)
      `CHK("halt", rows[k].hl, halt)
      if (rows[k].st) begin
        `CHK("erase", rows[k].ctl[ERASE_SEL_BIT], cmd.erase)
        `CHK("fetch", 1'b0, ok)
        rd(SELFPROG_CTRL_STATUS_OFS);
        `CHK("busy", 1'b1, rd_v[BUSY_FLAG_BIT])
        `CHK("active", 1'b1, rd_v[ACTIVE_BIT])
        `CHK("halt hold", rows[k].hl, halt)
        @(posedge ref_clk_i); fetch <= 16'hFE00;
        #1 `CHK("fetch stall area", 1'b1, ok)
        @(posedge ref_clk_i); fetch <= 16'h1000;
        wait_done;
        `CHK("halt end", 1'b0, halt)
        `CHK("addr", rows[k].tg & 16'hFF80, cmd.addr)
        `CHK("fetch held", 1'b0, ok)
        wr(SELFPROG_CTRL_STATUS_OFS, 8'h10);
        #1 `CHK("fetch free", 1'b1, ok)
      end
    end
    // slow flash; a clear while running must not drop the flag
    delay <= 8'h28;
    wr(SELFPROG_CTRL_STATUS_OFS, 8'h04);
    fire(16'hFE00, 16'h1000);
    wr(SELFPROG_CTRL_STATUS_OFS, 8'h10);
    wait_done;
    rd(SELFPROG_CTRL_STATUS_OFS);
    `CHK("busy kept", 1'b1, rd_v[BUSY_FLAG_BIT])
    wr(SELFPROG_CTRL_STATUS_OFS, 8'h10);
    // reset in the middle of a stalling op
    wr(SELFPROG_CTRL_STATUS_OFS, 8'h04);
    fire(16'hFE00, 16'hFE80);
    `CHK("halt slow", 1'b1, halt)
    @(posedge ref_clk_i); rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1 `CHK("rst mid halt", 1'b0, halt)
    `CHK("rst mid fetch", 1'b1, ok)
    @(posedge ref_clk_i); rst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1 `CHK("rst mid vector", 16'hFE00, rv)
    complete_run;
  end
endmodule
